// >>> rtl/converter_pwm_ctrl.sv
// converter pulse control with slot mask, lock, init flag and sample-ready pin
// Summary of operation
// - pulse scheduler runs at one quarter of the core input clock
// - one drive pulse per scheduling half period unless slot is masked
// - eight slots numbered zero to seven repeat in sequence
// - mask bit n governs slot n
// - mask bit one emits pulses, zero suppresses; all bits reset to one
// - slot mask lives in a software-writable 8-bit register
// - init status bit high about 20 ms after reset; host waits for zero
// - writing 0xca to the lock register protects configuration
// - new results drive the shared pin low for 64 input clocks
// - after reset the shared pin carries the sample-ready function
// - writing 0x9c to the lock register removes protection
// - setup bit 0 set puts the clock on the shared pin
`timescale 1ns/10ps
module converter_pwm_ctrl #(
    parameter int INIT_WAIT = conv_pwm_pkg::INIT_CYCLES,
    parameter int READY_LEN = conv_pwm_pkg::READY_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic new_sample,
    output logic shared_clock_ready_pin,
    output logic converter_pulse
);
    import conv_pwm_pkg::*;

    localparam int IW = $clog2(INIT_WAIT + 1);
    localparam int RW = $clog2(READY_LEN + 1);
    localparam logic [IW-1:0] INIT_LOAD = IW'(INIT_WAIT);
    localparam logic [RW-1:0] READY_LOAD = RW'(READY_LEN);

    logic [7:0] converter_slot_mask;
    logic [7:0] setup;
    logic locked;
    logic [IW-1:0] init_cnt;
    logic [RW-1:0] ready_cnt;
    logic clk_toggle;
    logic [7:0] primary_status_word;
    logic sched_pulse;

    logic [7:0] next_converter_slot_mask;
    logic [7:0] next_setup;
    logic next_locked;
    logic [IW-1:0] next_init_cnt;
    logic [RW-1:0] next_ready_cnt;
    logic next_clk_toggle;
    logic [7:0] next_reg_rdata;
    logic next_pin;
    logic init_busy;
    logic cfg_wr_ok;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        addr_hit = (a == target);
    endfunction : addr_hit

    pwm_slot_scheduler #(
        .DIV(SCHED_DIV),
        .SLOTS(SLOT_COUNT)
    ) u_sched (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .slot_mask(converter_slot_mask),
        .drive_pulse(sched_pulse),
        .slot()
    );

    // register block and init timer
    always_comb begin
        init_busy = (init_cnt != '0);
        next_init_cnt = init_busy ? IW'(init_cnt - 1'b1) : init_cnt;
        cfg_wr_ok = reg_wr && !init_busy && !locked;
        next_converter_slot_mask = converter_slot_mask;
        next_setup = setup;
        next_locked = locked;
        if (cfg_wr_ok && addr_hit(reg_addr, ADDR_SLOT_MASK)) begin
            next_converter_slot_mask = reg_wdata;
        end
        if (cfg_wr_ok && addr_hit(reg_addr, ADDR_SETUP)) begin
            next_setup = reg_wdata;
        end
        if (reg_wr && !init_busy && addr_hit(reg_addr, ADDR_LOCK)) begin
            if (reg_wdata == LOCK_KEY) begin
                next_locked = 1'b1;
            end else if (reg_wdata == UNLOCK_KEY) begin
                next_locked = 1'b0;
            end
        end
        primary_status_word = 8'h00;
        primary_status_word[STATUS_INIT_BIT] = init_busy;
        primary_status_word[STATUS_LOCK_BIT] = locked;
        case (reg_addr)
            ADDR_STATUS: next_reg_rdata = primary_status_word;
            ADDR_SETUP: next_reg_rdata = setup;
            ADDR_SLOT_MASK: next_reg_rdata = converter_slot_mask;
            ADDR_LOCK: next_reg_rdata = {7'h00, locked};
            default: next_reg_rdata = 8'h00;
        endcase
    end

    // shared pin: sample-ready pulse or clock output
    always_comb begin
        next_ready_cnt = ready_cnt;
        if (new_sample) begin
            next_ready_cnt = READY_LOAD;
        end else if (ready_cnt != '0) begin
            next_ready_cnt = RW'(ready_cnt - 1'b1);
        end
        next_clk_toggle = ~clk_toggle;
        if (setup[SETUP_CLK_SEL_BIT]) begin
            next_pin = next_clk_toggle;
        end else begin
            next_pin = (next_ready_cnt == '0);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_slot_mask <= SLOT_MASK_RESET;
            setup <= SETUP_RESET;
            locked <= 1'b0;
            init_cnt <= INIT_LOAD;
            ready_cnt <= '0;
            clk_toggle <= 1'b0;
            reg_rdata <= 8'h00;
            shared_clock_ready_pin <= 1'b1;
            converter_pulse <= 1'b0;
        end else begin
            converter_slot_mask <= next_converter_slot_mask;
            setup <= next_setup;
            locked <= next_locked;
            init_cnt <= next_init_cnt;
            ready_cnt <= next_ready_cnt;
            clk_toggle <= next_clk_toggle;
            reg_rdata <= next_reg_rdata;
            shared_clock_ready_pin <= next_pin;
            converter_pulse <= sched_pulse;
        end
    end

    a_lock_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
        locked && reg_wr && addr_hit(reg_addr, ADDR_SLOT_MASK) |=> $stable(converter_slot_mask))
        else $error("mask written while locked");
    a_lock_key: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && !init_busy && addr_hit(reg_addr, ADDR_LOCK) && reg_wdata == LOCK_KEY |=> locked)
        else $error("lock key did not lock");
    a_unlock_key: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && !init_busy && addr_hit(reg_addr, ADDR_LOCK) && reg_wdata == UNLOCK_KEY |=> !locked)
        else $error("unlock key did not unlock");
    a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && !locked && !init_busy && addr_hit(reg_addr, ADDR_SLOT_MASK)
        |=> converter_slot_mask == $past(reg_wdata) ##1 reg_rdata == converter_slot_mask
            || !addr_hit($past(reg_addr), ADDR_SLOT_MASK))
        else $error("mask write lost");
    a_init_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
        addr_hit(reg_addr, ADDR_STATUS) |=> reg_rdata[STATUS_INIT_BIT] == ($past(init_cnt) != '0))
        else $error("init flag wrong");
    a_ready_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
        new_sample && !setup[SETUP_CLK_SEL_BIT] && !next_setup[SETUP_CLK_SEL_BIT]
        |=> !shared_clock_ready_pin [*8])
        else $error("ready pulse too short");
    a_ready_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ready_cnt == RW'(1) && !new_sample && !setup[SETUP_CLK_SEL_BIT] |=> shared_clock_ready_pin)
        else $error("ready pulse too long");
    a_clock_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
        setup[SETUP_CLK_SEL_BIT] && $past(setup[SETUP_CLK_SEL_BIT])
        |=> shared_clock_ready_pin != $past(shared_clock_ready_pin))
        else $error("clock output not toggling");
    a_pulse_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        converter_pulse == $past(sched_pulse))
        else $error("converter pulse not registered from scheduler");
    a_setup_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
        locked && reg_wr && addr_hit(reg_addr, ADDR_SETUP) |=> $stable(setup))
        else $error("setup written while locked");
    a_init_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_busy && reg_wr |=> $stable(converter_slot_mask) && $stable(setup) && $stable(locked))
        else $error("write accepted during init");
    c_lock_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
        locked ##[1:100] !locked);
    c_ready_pulse: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(shared_clock_ready_pin) && !setup[SETUP_CLK_SEL_BIT]);
    c_init_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(init_busy));
endmodule : converter_pwm_ctrl

// >>> rtl/conv_pwm_pkg.sv
// constants for the converter pulse scheduler and its register block
package conv_pwm_pkg;
    // register addresses behind the register port
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_SETUP = 8'h01;
    localparam logic [7:0] ADDR_SLOT_MASK = 8'h02;
    localparam logic [7:0] ADDR_LOCK = 8'h03;
    // field positions
    localparam int STATUS_INIT_BIT = 0;
    localparam int STATUS_LOCK_BIT = 1;
    localparam int SETUP_CLK_SEL_BIT = 0;
    // reset values
    localparam logic [7:0] SLOT_MASK_RESET = 8'hff;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    // lock register keys
    localparam logic [7:0] LOCK_KEY = 8'hca;
    localparam logic [7:0] UNLOCK_KEY = 8'h9c;
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int INIT_TIME_MS = 20;
    localparam int INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam int READY_CYCLES = 64;
    localparam int SCHED_DIV = 4;
    localparam int SLOT_COUNT = 8;
endpackage : conv_pwm_pkg

// >>> rtl/pwm_slot_scheduler.sv
// slot-gated drive pulse scheduler at a quarter of the core clock
`timescale 1ns/10ps
module pwm_slot_scheduler #(
    parameter int DIV = conv_pwm_pkg::SCHED_DIV,
    parameter int SLOTS = conv_pwm_pkg::SLOT_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [SLOTS-1:0] slot_mask,
    output logic drive_pulse,
    output logic [$clog2(SLOTS)-1:0] slot
);
    import conv_pwm_pkg::*;

    localparam int PW = $clog2(DIV);
    localparam int SW = $clog2(SLOTS);
    localparam logic [PW-1:0] PHASE_LAST = PW'(DIV - 1);

    logic [PW-1:0] phase;
    logic [SLOTS-1:0] active_mask;
    logic [PW-1:0] next_phase;
    logic [SW-1:0] next_slot;
    logic [SLOTS-1:0] next_active_mask;
    logic next_drive_pulse;

    always_comb begin
        next_phase = phase + 1'b1;
        next_slot = slot;
        next_active_mask = active_mask;
        if (phase == PHASE_LAST) begin
            next_phase = '0;
            next_slot = SW'(slot + 1'b1);
            next_active_mask = slot_mask;
        end
        // one pulse each half period of the scheduling clock
        next_drive_pulse = (phase[0] == 1'b0) && active_mask[slot];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= '0;
            slot <= '0;
            active_mask <= '1;
            drive_pulse <= 1'b0;
        end else begin
            phase <= next_phase;
            slot <= next_slot;
            active_mask <= next_active_mask;
            drive_pulse <= next_drive_pulse;
        end
    end

    a_pulse_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        drive_pulse |-> $past(active_mask[slot]) && $past(phase[0]) == 1'b0)
        else $error("pulse in masked slot");
    a_slot_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        phase == PHASE_LAST |=> slot == SW'($past(slot) + 1'b1) && phase == '0)
        else $error("slot did not advance at boundary");
    a_mask_boundary: assert property (@(posedge sys_clk) disable iff (!rst_n)
        active_mask != $past(active_mask) |-> $past(phase) == PHASE_LAST)
        else $error("mask changed mid slot");
    a_pulse_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
        drive_pulse |=> !drive_pulse)
        else $error("pulses back to back");
    c_full_slot: cover property (@(posedge sys_clk) disable iff (!rst_n)
        drive_pulse ##2 drive_pulse);
    c_masked_slot: cover property (@(posedge sys_clk) disable iff (!rst_n)
        phase == '0 && !active_mask[slot]);
endmodule : pwm_slot_scheduler

// >>> dv/host_mcu_model.sv
// host microcontroller model on the register port
`timescale 1ns/10ps
module host_mcu_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    import conv_pwm_pkg::*;
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~v;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        reg_addr = a;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask : rd
    // poll init flag, then setup, mask and lock
    task automatic bring_up(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            rd(ADDR_STATUS, s);
            ok = (s[STATUS_INIT_BIT] === 1'b0);
        end
        if (ok) begin
            wr(ADDR_SETUP, SETUP_RESET);
            wr(ADDR_SLOT_MASK, 8'h55);
            wr(ADDR_LOCK, LOCK_KEY);
        end
    endtask : bring_up
endmodule : host_mcu_model

// >>> dv/isolated_converter_pwm_slot_gating_bench.sv
// bench for the slot-gated converter pulse control
`timescale 1ns/10ps
`define CMP(e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g); end end
module isolated_converter_pwm_slot_gating_bench;
    import conv_pwm_pkg::*;
    logic sys_clk, rst_n, reg_wr, new_sample, shared_clock_ready_pin, converter_pulse, ok;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, m;
    logic [15:0] exp_q[$], got_q[$], e, g;
    logic [31:0] rnd = 32'h0e5553cb;
    int err_count = 0, comparisons = 0, cyc = 0, low = 0, n, c, p1, p2, base;
    converter_pwm_ctrl #(.INIT_WAIT(20), .READY_LEN(READY_CYCLES)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .new_sample(new_sample), .shared_clock_ready_pin(shared_clock_ready_pin), .converter_pulse(converter_pulse));
    host_mcu_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    always @(posedge sys_clk) if (shared_clock_ready_pin === 1'b0) low <= low + 1;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic note(input logic [15:0] ex, input logic [15:0] gv);
        exp_q.push_back(ex);
        got_q.push_back(gv);
    endtask : note
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
        host.rd(a, d);
        note({8'h00, ex}, {8'h00, d});
    endtask : rd_chk
    task automatic stop_test;
        @(posedge sys_clk);
        #1;
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic next_pulse(output int t);
        t = -1;
        for (int i = 0; i < 100 && t < 0; i++) begin
            @(negedge sys_clk);
            if (converter_pulse === 1'b1) t = cyc;
        end
        if (t < 0) begin
            err_count++;
            stop_test;
        end
    endtask : next_pulse
    always @(posedge sys_clk) begin
        while (got_q.size() != 0) begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            `CMP(e, g)
        end
    end
    initial begin
        rst_n = 1'b0;
        new_sample = 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        rd_chk(ADDR_STATUS, 8'h01);
        host.wr(ADDR_SLOT_MASK, 8'h00);
        rd_chk(ADDR_SLOT_MASK, SLOT_MASK_RESET);
        rd_chk(ADDR_SETUP, SETUP_RESET);
        note(16'h0001, {15'h0, shared_clock_ready_pin});
        host.bring_up(ok);
        if (!ok) begin
            err_count++;
            stop_test;
        end
        rd_chk(ADDR_STATUS, 8'h02);
        host.wr(ADDR_SLOT_MASK, 8'h0f);
        rd_chk(ADDR_SLOT_MASK, 8'h55);
        host.wr(ADDR_SETUP, 8'h01);
        rd_chk(ADDR_SETUP, SETUP_RESET);
        host.wr(ADDR_LOCK, 8'h11);
        host.wr(ADDR_LOCK, UNLOCK_KEY);
        rd_chk(ADDR_STATUS, 8'h00);
        rd_chk(8'h04, 8'h00);
        for (n = 0; n < 12; n++) begin
            rnd = lfsr(rnd);
            m = (n < 8) ? 8'h01 << n : (n == 8) ? 8'haa : rnd[7:0];
            host.wr(ADDR_SLOT_MASK, m);
            repeat (40) @(negedge sys_clk);
            c = 0;
            repeat (32) begin
                @(negedge sys_clk);
                if (converter_pulse === 1'b1) c++;
            end
            note(16'(2 * $countones(m)), 16'(c));
            if (n < 8) begin
                next_pulse(p1);
                next_pulse(p2);
                if (p2 - p1 != 2) p1 = p2;
                if (n == 0) base = p1;
                note(16'(4 * n), 16'((p1 - base) % 32));
            end
        end
        @(negedge sys_clk) new_sample = 1'b1;
        low = 0;
        @(negedge sys_clk) new_sample = 1'b0;
        repeat (16) @(negedge sys_clk);
        rd_chk(ADDR_STATUS, 8'h00);
        new_sample = 1'b1;
        @(negedge sys_clk) new_sample = 1'b0;
        repeat (150) @(negedge sys_clk);
        note(16'(19 + READY_CYCLES), 16'(low));
        host.wr(ADDR_SETUP, 8'h01);
        repeat (4) @(negedge sys_clk);
        low = 0;
        repeat (16) @(negedge sys_clk);
        note(16'd8, 16'(low));
        @(negedge sys_clk) rst_n = 1'b0;
        @(negedge sys_clk) rst_n = 1'b1;
        rd_chk(ADDR_SETUP, SETUP_RESET);
        note(16'h0001, {15'h0, shared_clock_ready_pin});
        rd_chk(ADDR_SLOT_MASK, SLOT_MASK_RESET);
        rd_chk(ADDR_STATUS, 8'h01);
        stop_test;
    end
endmodule : isolated_converter_pwm_slot_gating_bench
